// ### logic/cfs_pkg.sv
package cfs_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_OFF_DELAY = 6'h04;
  localparam logic [5:0] REG_OFF_FALL = 6'h08;
  localparam logic [5:0] REG_OC_WARN = 6'h0c;
  localparam logic [5:0] REG_OC_FAULT = 6'h10;
  localparam logic [5:0] REG_OT_LIMIT = 6'h14;
  localparam logic [5:0] REG_IOUT = 6'h18;
  localparam logic [5:0] REG_LOAD_CURRENT = 6'h1c;
  localparam logic [5:0] REG_DIE_HEAT = 6'h20;
  localparam logic [5:0] REG_STATUS = 6'h24;
  // ==========================================
  // Control register layout
  typedef struct packed {
    logic [1:0] ot_resp;
    logic oc_latch;
    logic pin_programmed_voltage_mode;
    logic soft_off;
    logic pin_en_req;
    logic cmd_sd_en;
    logic conv_on;
  } cfs_ctrl_t;
  localparam int CTRL_W = 8;
  localparam int CTRL_CLR_BIT = 8;
  localparam cfs_ctrl_t CTRL_RST = 8'h45;
  localparam logic [1:0] OT_IGNORE = 2'h0;
  localparam logic [1:0] OT_INHIBIT = 2'h1;
  localparam logic [1:0] OT_LATCH = 2'h2;
  // ==========================================
  // Reset values
  localparam logic [6:0] DELAY_RST = 7'h00;
  localparam logic [6:0] FALL_RST = 7'h01;
  localparam logic [15:0] OC_WARN_RST = 16'h0190;
  localparam logic [15:0] OC_FAULT_RST = 16'h0200;
  localparam logic [7:0] OT_LIMIT_RST = 8'h7d;
  localparam logic [8:0] TEMP_OFS = 9'h028;
  localparam logic [8:0] TEMP_HYST = 9'h019;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_NS = 4;
  localparam int MS_CYC_DEF = CLK_MHZ * 1000;
  localparam int HICCUP_MS = 20;
  localparam int SAMPLE_NS = 75;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEW_NS_PER_MV = 1600;
  localparam int SLEW_CYC = SLEW_NS_PER_MV / CLK_NS;
  localparam logic [3:0] OC_TOTAL_MAX = 4'h8;
  localparam logic [1:0] OC_RUN_LEN = 2'h3;
  localparam logic [2:0] OK_RUN_LEN = 3'h4;
  localparam logic [8:0] FRAC_FULL = 9'h100;
  // ==========================================
  // Supervisor states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_DELAY = 3'b010,
    ST_STOP = 3'b011,
    ST_HICCUP = 3'b100,
    ST_OT_WAIT = 3'b101,
    ST_LATCHED = 3'b110
  } cfs_state_t;
endpackage : cfs_pkg

// ### logic/cfs_top.sv
`timescale 1ns/100ps
// Function
// - Enable pin low in default setup turns off both gate drivers.
// - Default shutdown is immediate, without delay or ramp.
// - Shutdown via OPERATION command is optional in both modes.
// - Bus mode soft-off waits 0 to 127 ms before turn-off.
// - Bus mode soft-stop ramp lasts 1 to 127 ms.
// - Turn-off delay only applies in bus mode.
// - Pin voltage mode soft-stop slews target down at fixed rate.
// - Report average current with one sixteenth ampere resolution.
// - Eight-bit current register in quarter ampere counts.
// - Warning when average current exceeds the warn limit.
// - Sample low-side current 75 ns from set pulse rise; set pulse is period/8.
// - High-side pulse starts at set pulse falling edge.
// - Eight total trips cause 20 ms enable-low hiccup, repeated.
// - Fault threshold programmable; host should use at least 16 A.
// - Fault response selects latched shutdown or hiccup, hiccup default.
// - Below duty 1/8 only count trips, no duty reduction.
// - Three consecutive trips step duty to 0.5, 0.25, 0.125.
// - Four consecutive clean cycles double the limited duty.
// - Die temperature register equals temperature minus forty degrees.
// - Default trip 125 C; exceeding it turns both switches off.
// - Restart once temperature is below trip minus 25 degrees.
// - Overtemperature response is ignore, inhibit or latch.
module cfs_top
  import cfs_pkg::*;
#(
  parameter int P_MS_CYC = MS_CYC_DEF
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_EN_HIGH,
  input wire logic [11:0] I_PERIOD_LEN,
  input wire logic [11:0] I_ON_CYC,
  input wire logic I_OC_CMP,
  input wire logic [15:0] I_IOUT,
  input wire logic I_IOUT_VALID,
  input wire logic [7:0] I_TEMP_CODE,
  input wire logic [11:0] I_VSET_MV,
  output logic O_HS_ON,
  output logic O_LS_ON,
  output logic O_SET_PULSE,
  output logic O_OC_SAMPLE,
  output logic O_CONV_EN,
  output logic [11:0] O_VREF_MV,
  output logic [15:0] O_OC_LIMIT
);
  localparam int SUB_CYC = P_MS_CYC / 256;

  cfs_ctrl_t ctrl;
  cfs_state_t state;
  logic [6:0] off_delay;
  logic [6:0] off_fall;
  logic [15:0] oc_warn_lim;
  logic [7:0] ot_limit;
  logic [15:0] iout;
  logic [7:0] temp_code;
  logic oc_warn;
  logic oc_flt;
  logic ot_flt;
  logic clr_pulse;
  logic [31:0] rd_val;
  logic acc;
  logic [15:0] sub_cnt;
  logic [7:0] sub_idx;
  logic sub_tick;
  logic ms_tick;
  logic [6:0] tcnt;
  logic [6:0] rcnt;
  logic [8:0] frac;
  logic [8:0] slew_cnt;
  logic [11:0] pcnt;
  logic [11:0] set_w;
  logic [11:0] on_lim;
  logic [11:0] on_eff;
  logic [12:0] hs_end;
  logic period_end;
  logic oc_seen;
  logic low_duty;
  logic [3:0] oc_total;
  logic [1:0] over_cnt;
  logic [2:0] ok_cnt;
  logic [1:0] dc_step;
  logic oc_evt;
  logic running;
  logic conv_req;
  logic en_prev;
  logic ot_trip;
  logic ot_clear;
  logic [20:0] vprod;
  logic next_hs;

  function automatic logic [11:0] cfs_min12(input logic [11:0] a, input logic [11:0] b);
    cfs_min12 = (a < b) ? a : b;
  endfunction : cfs_min12

  // ==========================================
  // Avalon slave: one wait cycle, then the answer.
  assign acc = (I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST;
  assign clr_pulse = I_AVS_WRITE & ~O_AVS_WAITREQUEST & (I_AVS_ADDRESS == REG_CTRL)
                     & I_AVS_WRITEDATA[CTRL_CLR_BIT];

  always_comb begin
    rd_val = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      REG_CTRL: rd_val = {24'h00_0000, ctrl};
      REG_OFF_DELAY: rd_val = {25'h000_0000, off_delay};
      REG_OFF_FALL: rd_val = {25'h000_0000, off_fall};
      REG_OC_WARN: rd_val = {16'h0000, oc_warn_lim};
      REG_OC_FAULT: rd_val = {16'h0000, O_OC_LIMIT};
      REG_OT_LIMIT: rd_val = {24'h00_0000, ot_limit};
      REG_IOUT: rd_val = {16'h0000, iout};
      REG_LOAD_CURRENT: begin
        rd_val = {24'h00_0000, (iout[15:10] != 6'h00) ? 8'hff : iout[9:2]};
      end
      REG_DIE_HEAT: rd_val = {24'h00_0000, temp_code};
      REG_STATUS: begin
        rd_val = {22'h00_0000, dc_step, 1'b0, state, 1'b0, ot_flt, oc_flt, oc_warn};
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (acc) begin
      O_AVS_WAITREQUEST <= 1'b0;
      O_AVS_READDATA <= I_AVS_READ ? rd_val : 32'h0000_0000;
    end else begin
      O_AVS_WAITREQUEST <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl <= CTRL_RST;
      off_delay <= DELAY_RST;
      off_fall <= FALL_RST;
      oc_warn_lim <= OC_WARN_RST;
      O_OC_LIMIT <= OC_FAULT_RST;
      ot_limit <= OT_LIMIT_RST;
    end else if (I_AVS_WRITE & ~O_AVS_WAITREQUEST) begin
      case (I_AVS_ADDRESS)
        REG_CTRL: ctrl <= I_AVS_WRITEDATA[CTRL_W-1:0];
        REG_OFF_DELAY: off_delay <= I_AVS_WRITEDATA[6:0];
        REG_OFF_FALL: begin
          off_fall <= (I_AVS_WRITEDATA[6:0] == 7'h00) ? 7'h01 : I_AVS_WRITEDATA[6:0];
        end
        REG_OC_WARN: oc_warn_lim <= I_AVS_WRITEDATA[15:0];
        REG_OC_FAULT: O_OC_LIMIT <= I_AVS_WRITEDATA[15:0];
        REG_OT_LIMIT: ot_limit <= I_AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Telemetry and sticky flags; a set wins over a clear.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      iout <= 16'h0000;
      temp_code <= 8'h00;
    end else begin
      if (I_IOUT_VALID) begin
        iout <= I_IOUT;
      end
      temp_code <= I_TEMP_CODE;
    end
  end

  assign ot_trip = ({1'b0, temp_code} + TEMP_OFS) > {1'b0, ot_limit};
  assign ot_clear = ({1'b0, temp_code} + TEMP_OFS + TEMP_HYST) < {1'b0, ot_limit};

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oc_warn <= 1'b0;
      oc_flt <= 1'b0;
      ot_flt <= 1'b0;
    end else begin
      oc_warn <= (iout > oc_warn_lim) | (oc_warn & ~clr_pulse);
      oc_flt <= oc_evt | (oc_flt & ~clr_pulse);
      ot_flt <= (ot_trip & (ctrl.ot_resp != OT_IGNORE)) | (ot_flt & ~clr_pulse);
    end
  end

  // ==========================================
  // Millisecond time base as 256 sub-ticks.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sub_cnt <= 16'h0000;
      sub_idx <= 8'h00;
    end else if ((state == ST_RUN) || (state == ST_OFF)) begin
      // Restart the time base so that delay, and hiccup entered from run, count whole milliseconds from entry.
      sub_cnt <= 16'h0000;
      sub_idx <= 8'h00;
    end else if (sub_tick) begin
      sub_cnt <= 16'h0000;
      sub_idx <= sub_idx + 8'h01;
    end else begin
      sub_cnt <= sub_cnt + 16'h0001;
    end
  end

  assign sub_tick = (sub_cnt == 16'(SUB_CYC - 1));
  assign ms_tick = sub_tick & (sub_idx == 8'hff);

  // ==========================================
  // Supervisor state machine.
  assign conv_req = (I_EN_HIGH | ~ctrl.pin_en_req) & (ctrl.conv_on | ~ctrl.cmd_sd_en);
  assign running = (state == ST_RUN) | (state == ST_DELAY) | (state == ST_STOP);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= conv_req;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= ST_OFF;
      tcnt <= 7'h00;
    end else begin
      case (state)
        ST_OFF: begin
          tcnt <= 7'h00;
          if (conv_req & ~(ot_trip & (ctrl.ot_resp != OT_IGNORE))) begin
            state <= ST_RUN;
          end
        end
        ST_RUN, ST_DELAY, ST_STOP: begin
          if (oc_evt) begin
            state <= ctrl.oc_latch ? ST_LATCHED : ST_HICCUP;
            tcnt <= 7'h00;
          end else if (ot_trip & (ctrl.ot_resp == OT_LATCH)) begin
            state <= ST_LATCHED;
          end else if (ot_trip & (ctrl.ot_resp == OT_INHIBIT)) begin
            state <= ST_OT_WAIT;
          end else if (state == ST_RUN) begin
            if (!conv_req) begin
              if (!ctrl.soft_off) begin
                state <= ST_OFF;
              end else if (!ctrl.pin_programmed_voltage_mode && off_delay != 7'h00) begin
                state <= ST_DELAY;
                tcnt <= 7'h00;
              end else begin
                state <= ST_STOP;
              end
            end
          end else if (state == ST_DELAY) begin
            if (ms_tick) begin
              tcnt <= tcnt + 7'h01;
              if (tcnt + 7'h01 == off_delay) begin
                state <= ST_STOP;
              end
            end
          end else if (O_VREF_MV == 12'h000) begin
            state <= ST_OFF;
          end
        end
        ST_HICCUP: begin
          if (ms_tick) begin
            tcnt <= tcnt + 7'h01;
            if (tcnt == 7'(HICCUP_MS - 1)) begin
              state <= ST_OFF;
            end
          end
        end
        ST_OT_WAIT: begin
          if (ot_clear) begin
            state <= ST_OFF;
          end
        end
        ST_LATCHED: begin
          if (clr_pulse | (en_prev & ~conv_req)) begin
            state <= ST_OFF;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ==========================================
  // Output target and soft-stop ramp.
  assign vprod = I_VSET_MV * frac;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_VREF_MV <= 12'h000;
      frac <= FRAC_FULL;
      rcnt <= 7'h00;
      slew_cnt <= 9'h000;
    end else if (state == ST_STOP) begin
      if (!ctrl.pin_programmed_voltage_mode) begin
        O_VREF_MV <= vprod[19:8];
        if (sub_tick && frac != 9'h000) begin
          if (rcnt + 7'h01 >= off_fall) begin
            rcnt <= 7'h00;
            frac <= frac - 9'h001;
          end else begin
            rcnt <= rcnt + 7'h01;
          end
        end
      end else if (slew_cnt == 9'(SLEW_CYC - 1)) begin
        slew_cnt <= 9'h000;
        if (O_VREF_MV != 12'h000) begin
          O_VREF_MV <= O_VREF_MV - 12'h001;
        end
      end else begin
        slew_cnt <= slew_cnt + 9'h001;
      end
    end else begin
      frac <= FRAC_FULL;
      rcnt <= 7'h00;
      slew_cnt <= 9'h000;
      O_VREF_MV <= running ? I_VSET_MV : 12'h000;
    end
  end

  // ==========================================
  // Switching period, set pulse and sampling window.
  assign set_w = {3'b000, I_PERIOD_LEN[11:3]};
  assign period_end = (pcnt + 12'h001 >= I_PERIOD_LEN);
  assign low_duty = (I_ON_CYC < set_w);

  always_comb begin
    case (dc_step)
      2'h1: on_lim = {1'b0, I_PERIOD_LEN[11:1]};
      2'h2: on_lim = {2'b00, I_PERIOD_LEN[11:2]};
      2'h3: on_lim = set_w;
      default: on_lim = I_PERIOD_LEN;
    endcase
  end

  assign on_eff = low_duty ? I_ON_CYC : cfs_min12(I_ON_CYC, on_lim);
  assign hs_end = {1'b0, set_w} + {1'b0, on_eff};
  assign next_hs = running & (pcnt >= set_w) & ({1'b0, pcnt} < hs_end);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pcnt <= 12'h000;
    end else if (!running || period_end) begin
      // A new run always starts with a whole period and a full set pulse.
      pcnt <= 12'h000;
    end else begin
      pcnt <= pcnt + 12'h001;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_HS_ON <= 1'b0;
      O_LS_ON <= 1'b0;
      O_SET_PULSE <= 1'b0;
      O_OC_SAMPLE <= 1'b0;
      O_CONV_EN <= 1'b0;
    end else begin
      O_HS_ON <= next_hs;
      O_LS_ON <= running & ~next_hs;
      O_SET_PULSE <= running & (pcnt < set_w);
      O_OC_SAMPLE <= running & (pcnt < 12'(SAMPLE_CYC));
      O_CONV_EN <= running;
    end
  end

  // ==========================================
  // Overcurrent sampling and duty stepping.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oc_seen <= 1'b0;
    end else if (pcnt == 12'h000) begin
      oc_seen <= I_OC_CMP;
    end else if (pcnt < 12'(SAMPLE_CYC)) begin
      oc_seen <= oc_seen | I_OC_CMP;
    end
  end

  assign oc_evt = running & period_end & oc_seen & (oc_total == OC_TOTAL_MAX - 4'h1);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oc_total <= 4'h0;
      over_cnt <= 2'h0;
      ok_cnt <= 3'h0;
      dc_step <= 2'h0;
    end else if (!running) begin
      oc_total <= 4'h0;
      over_cnt <= 2'h0;
      ok_cnt <= 3'h0;
      dc_step <= 2'h0;
    end else if (period_end) begin
      if (oc_seen) begin
        ok_cnt <= 3'h0;
        if (oc_total != OC_TOTAL_MAX) begin
          oc_total <= oc_total + 4'h1;
        end
        if (!low_duty) begin
          if (over_cnt == OC_RUN_LEN - 2'h1) begin
            over_cnt <= 2'h0;
            if (dc_step != 2'h3) begin
              dc_step <= dc_step + 2'h1;
            end
          end else begin
            over_cnt <= over_cnt + 2'h1;
          end
        end
      end else begin
        over_cnt <= 2'h0;
        if (ok_cnt == OK_RUN_LEN - 3'h1) begin
          ok_cnt <= 3'h0;
          if (dc_step != 2'h0) begin
            dc_step <= dc_step - 2'h1;
          end else begin
            oc_total <= 4'h0;
          end
        end else begin
          ok_cnt <= ok_cnt + 3'h1;
        end
      end
    end
  end
endmodule : cfs_top

// ### verification/cfs_stage_model.sv
`timescale 1ns/100ps
// ==========================================
// Power stage: valley comparator and averaging current ADC.
module cfs_stage_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_overload,
  input wire logic [15:0] i_amps,
  output logic o_oc_cmp,
  output logic [15:0] o_iout,
  output logic o_iout_valid
);
  logic [3:0] tick;
  // The comparator level follows the load with one cycle of delay.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick <= 4'h0;
      o_oc_cmp <= 1'b0;
      o_iout_valid <= 1'b0;
      o_iout <= 16'h0000;
    end else begin
      tick <= tick + 4'h1;
      o_oc_cmp <= i_overload;
      // Outside the load pulse the bus carries the inverse, never a stale sample.
      o_iout_valid <= (tick == 4'h0);
      o_iout <= (tick == 4'h0) ? i_amps : ~i_amps;
    end
  end
endmodule : cfs_stage_model

// ### verification/cfs_top_checker.sv
`timescale 1ns/100ps
module cfs_top_checker
  import cfs_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [11:0] I_PERIOD_LEN,
  input wire logic O_HS_ON,
  input wire logic O_LS_ON,
  input wire logic O_SET_PULSE,
  input wire logic O_OC_SAMPLE,
  input wire logic O_CONV_EN,
  input wire logic [11:0] O_VREF_MV,
  input wire logic [15:0] O_OC_LIMIT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic [11:0] set_cnt;
  logic [11:0] samp_cnt;
  // Run lengths of the set pulse and of the sampling window.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      set_cnt <= 12'h000;
      samp_cnt <= 12'h000;
    end else begin
      set_cnt <= O_SET_PULSE ? set_cnt + 12'h001 : 12'h000;
      samp_cnt <= O_OC_SAMPLE ? samp_cnt + 12'h001 : 12'h000;
    end
  end
  a_gates_off: assert property (!O_CONV_EN |-> !O_HS_ON && !O_LS_ON)
    else $error("gate driven while conversion is off");
  a_gates_excl: assert property (!(O_HS_ON && O_LS_ON))
    else $error("both gates on");
  a_hs_blank: assert property (O_SET_PULSE |-> !O_HS_ON && O_LS_ON)
    else $error("high side on during set pulse");
  a_set_width: assert property ($fell(O_SET_PULSE) && O_HS_ON |-> set_cnt == I_PERIOD_LEN >> 3)
    else $error("set pulse width wrong");
  a_sample_len: assert property ($fell(O_OC_SAMPLE) && O_CONV_EN |-> samp_cnt == 12'h013)
    else $error("sample window length wrong");
  a_sample_start: assert property ($rose(O_OC_SAMPLE) |-> $rose(O_SET_PULSE))
    else $error("sample window not aligned to set pulse");
  a_limit_write: assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == REG_OC_FAULT
    |-> ##2 O_OC_LIMIT == $past(I_AVS_WRITEDATA[15:0], 2))
    else $error("fault limit not applied");
  a_vref_off: assert property (!O_CONV_EN |-> O_VREF_MV == 12'h000)
    else $error("target nonzero while off");
  a_hs_follows: assert property ($fell(O_SET_PULSE) && O_CONV_EN |-> O_HS_ON || !O_LS_ON)
    else $error("high side did not start at set pulse end");
  c_stop: cover property ($fell(O_CONV_EN));
  c_period: cover property ($rose(O_SET_PULSE));
  c_write: cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
endmodule : cfs_top_checker

bind cfs_top cfs_top_checker cfs_top_checker_inst (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_PERIOD_LEN(I_PERIOD_LEN), .O_HS_ON(O_HS_ON),
  .O_LS_ON(O_LS_ON), .O_SET_PULSE(O_SET_PULSE), .O_OC_SAMPLE(O_OC_SAMPLE),
  .O_CONV_EN(O_CONV_EN), .O_VREF_MV(O_VREF_MV), .O_OC_LIMIT(O_OC_LIMIT));

// ### verification/tb_cfs_top.sv
`timescale 1ns/100ps
module tb_cfs_top;
  import cfs_pkg::*;
  localparam int MS = 256;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic en = 1'b1;
  logic [11:0] on_cyc = 12'h028;
  logic ovl = 1'b0;
  logic [15:0] amps = 16'h0123;
  logic [7:0] temp = 8'h20;
  logic [11:0] vset = 12'h320;
  logic [31:0] rdata;
  logic waitreq, oc_cmp, iout_valid, hs, ls, setp, samp, conv, set_q;
  logic [15:0] iout;
  logic [15:0] lim;
  logic [11:0] vref;
  int fail_count = 0;
  int checks = 0;
  int cnt;
  int hs_n = 0;
  int widths[$];
  always #2 clk = ~clk;
  cfs_top #(.P_MS_CYC(MS)) cfs_top_inst (.I_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .I_EN_HIGH(en), .I_PERIOD_LEN(12'h040), .I_ON_CYC(on_cyc),
    .I_OC_CMP(oc_cmp), .I_IOUT(iout), .I_IOUT_VALID(iout_valid), .I_TEMP_CODE(temp),
    .I_VSET_MV(vset), .O_HS_ON(hs), .O_LS_ON(ls), .O_SET_PULSE(setp), .O_OC_SAMPLE(samp),
    .O_CONV_EN(conv), .O_VREF_MV(vref), .O_OC_LIMIT(lim));
  cfs_stage_model cfs_stage_model_inst (.i_clk(clk), .i_nrst(nrst), .i_overload(ovl),
    .i_amps(amps), .o_oc_cmp(oc_cmp), .o_iout(iout), .o_iout_valid(iout_valid));
  // ==========================================
  // High-side on time of each switching period.
  always @(posedge clk) begin
    set_q <= setp;
    if (setp && !set_q) begin
      widths.push_back(hs_n);
      hs_n = 0;
    end else if (hs) begin
      hs_n++;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rdata, exp);
  endtask : rchk
  task automatic wait_conv(input logic lvl, input int lmt);
    cnt = 0;
    while (conv !== lvl) begin
      @(posedge clk);
      cnt++;
      if (cnt > lmt) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask : wait_conv
  task automatic last_widths(input int w0, input int w1, input int w2);
    int n;
    int ew[7];
    n = widths.size();
    ew = '{w0, w0, w0, w1, w1, w1, w2};
    for (int i = 0; i < 7; i++) check("hs width", widths[n - 7 + i], ew[i]);
  endtask : last_widths
  // ==========================================
  // Main sequence.
  logic [5:0] ra[7] = '{REG_CTRL, REG_OFF_DELAY, REG_OFF_FALL, REG_OC_WARN, REG_OC_FAULT,
    REG_OT_LIMIT, 6'h3c};
  logic [31:0] rv[7] = '{32'h45, 32'h0, 32'h1, 32'h190, 32'h200, 32'h7d, 32'h0};
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rchk("reset value", ra[i], rv[i]);
    bus(1'b1, REG_OFF_FALL, 32'h0);
    rchk("fall floor", REG_OFF_FALL, 32'h1);
    bus(1'b1, REG_IOUT, 32'hffff);
    rchk("iout", REG_IOUT, 32'h123);
    rchk("load current", REG_LOAD_CURRENT, 32'h48);
    rchk("die heat", REG_DIE_HEAT, 32'h20);
    rchk("warn low", REG_STATUS, 32'h10);
    amps <= 16'h0500;
    repeat (40) @(posedge clk);
    rchk("load sat", REG_LOAD_CURRENT, 32'hff);
    rchk("warn high", REG_STATUS, 32'h11);
    amps <= 16'h0123;
    en <= 1'b0;
    wait_conv(1'b0, 3);
    en <= 1'b1;
    wait_conv(1'b1, 5);
    bus(1'b1, REG_CTRL, 32'h46);
    wait_conv(1'b0, 4);
    bus(1'b1, REG_OFF_DELAY, 32'h2);
    bus(1'b1, REG_OFF_FALL, 32'h3);
    bus(1'b1, REG_CTRL, 32'h4f);
    wait_conv(1'b1, 5);
    bus(1'b1, REG_CTRL, 32'h4e);
    wait_conv(1'b0, 2000);
    check("soft off time", cnt >= 5 * MS - 4 && cnt <= 5 * MS + 8, 1);
    vset <= 12'h00a;
    bus(1'b1, REG_CTRL, 32'h5f);
    wait_conv(1'b1, 5);
    bus(1'b1, REG_CTRL, 32'h5e);
    wait_conv(1'b0, 5000);
    check("pin mode stop", cnt >= 3992 && cnt <= 4010, 1);
    vset <= 12'h320;
    bus(1'b1, REG_CTRL, 32'h45);
    wait_conv(1'b1, 5);
    temp <= 8'h56;
    wait_conv(1'b0, 4);
    rchk("ot wait", REG_STATUS, 32'h55);
    temp <= 8'h3c;
    repeat (50) @(posedge clk);
    check("ot hold", conv, 1'b0);
    temp <= 8'h3b;
    wait_conv(1'b1, 10);
    bus(1'b1, REG_CTRL, 32'h185);
    temp <= 8'h56;
    wait_conv(1'b0, 4);
    temp <= 8'h20;
    repeat (50) @(posedge clk);
    check("ot latch", conv, 1'b0);
    bus(1'b1, REG_CTRL, 32'h105);
    wait_conv(1'b1, 10);
    temp <= 8'h56;
    repeat (50) @(posedge clk);
    check("ot ignore", conv, 1'b1);
    temp <= 8'h20;
    bus(1'b1, REG_CTRL, 32'h145);
    ovl <= 1'b1;
    wait_conv(1'b0, 700);
    last_widths(40, 32, 16);
    wait_conv(1'b1, 6000);
    check("hiccup time", cnt >= 20 * MS - 2 && cnt <= 20 * MS + 8, 1);
    wait_conv(1'b0, 600);
    on_cyc <= 12'h004;
    wait_conv(1'b1, 6000);
    wait_conv(1'b0, 600);
    last_widths(4, 4, 4);
    ovl <= 1'b0;
    on_cyc <= 12'h028;
    bus(1'b1, REG_CTRL, 32'h65);
    wait_conv(1'b1, 6000);
    ovl <= 1'b1;
    wait_conv(1'b0, 700);
    ovl <= 1'b0;
    repeat (6000) @(posedge clk);
    rchk("oc latch", REG_STATUS, 32'h62);
    bus(1'b1, REG_CTRL, 32'h165);
    wait_conv(1'b1, 10);
    ovl <= 1'b1;
    repeat (300) @(posedge clk);
    ovl <= 1'b0;
    repeat (1500) @(posedge clk);
    last_widths(40, 40, 40);
    check("recovered run", conv, 1'b1);
    tally_and_finish();
  end
endmodule : tb_cfs_top
